//--- hdl/ipsa_map.vh
// Purpose: constants for the input pin signal assignment block
// Assumes: avalon-mm word addressing, 32-bit data
// Notes: selection registers hold one hex digit per control mode
`ifndef IPSA_MAP_VH
`define IPSA_MAP_VH

`define IPSA_ADDR_W 4
`define IPSA_OFF_SEL_B5 4'h0
`define IPSA_OFF_SEL_B14 4'h1
`define IPSA_OFF_SEL_A8 4'h2
`define IPSA_OFF_SEL_B7 4'h3
`define IPSA_OFF_SEL_B8 4'h4
`define IPSA_OFF_SEL_B9 4'h5
`define IPSA_OFF_CTRL 4'h6
`define IPSA_OFF_STATUS 4'h7
`define IPSA_OFF_PINS 4'h8

`define IPSA_RST_SEL_B5 16'h0111
`define IPSA_RST_SEL_B14 16'h0222
`define IPSA_RST_SEL_A8 16'h0665
`define IPSA_RST_SEL_B7 16'h0770
`define IPSA_RST_SEL_B8 16'h0883
`define IPSA_RST_SEL_B9 16'h0994
`define IPSA_RST_LOP_PIN 3'h3
`define IPSA_RST_CTRL 32'h0000_0000

// ctrl register fields
`define IPSA_CTRL_MODE_LSB 0
`define IPSA_CTRL_MODE_MSB 1
`define IPSA_CTRL_MODE_SW_LSB 2
`define IPSA_CTRL_MODE_SW_MSB 3
`define IPSA_CTRL_ABS_BIT 4
`define IPSA_CTRL_LOP_LSB 8
`define IPSA_CTRL_LOP_MSB 10

// control modes and change modes
`define IPSA_MODE_POS 2'h0
`define IPSA_MODE_SPD 2'h1
`define IPSA_MODE_TRQ 2'h2
`define IPSA_SW_NONE 2'h0
`define IPSA_SW_PS 2'h1
`define IPSA_SW_ST 2'h2
`define IPSA_SW_TP 2'h3

// control-mode change pin codes
`define IPSA_LOP_B5 3'h0
`define IPSA_LOP_B14 3'h1
`define IPSA_LOP_A8 3'h2
`define IPSA_LOP_A7 3'h3
`define IPSA_LOP_B9 3'h4

// pin index order
`define IPSA_PIN_B5 0
`define IPSA_PIN_B14 1
`define IPSA_PIN_A8 2
`define IPSA_PIN_B7 3
`define IPSA_PIN_B8 4
`define IPSA_PIN_B9 5

// digit positions in a selection value
`define IPSA_DIG_POS_LSB 0
`define IPSA_DIG_SPD_LSB 4
`define IPSA_DIG_TRQ_LSB 8

`define IPSA_FUNC_ABS_POSITION_TRANSFER_MODE 4'hE
`define IPSA_FUNC_ABS_POSITION_REQUEST 4'hF
`define IPSA_FUNC_NONE 4'h0

`endif

//--- hdl/ipsa_pin_route.v
// Purpose: one input pin: synchroniser and function code selection
// Assumes: pin level is asynchronous to clk_i
// Notes: code 0 means no function
`timescale 1ns/1ps
`include "ipsa_map.vh"

module ipsa_pin_route #(
  parameter SEL_W = 16
) (
  input wire clk_i,
  input wire resetn_i,
  input wire pin_i,
  input wire [SEL_W-1:0] sel_i,
  input wire [1:0] mode_i,
  input wire lop_here_i,
  input wire abs_force_i,
  input wire [3:0] abs_func_i,
  output reg [3:0] func_o,
  output reg level_o
);

  reg sync1_reg;
  reg sync2_reg;
  reg [3:0] digit;

  // --------------------------------
  // two-stage synchroniser
  // --------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // --------------------------------
  // digit per active mode
  // --------------------------------
  always @* begin
    case (mode_i)
      `IPSA_MODE_POS: digit = sel_i[`IPSA_DIG_POS_LSB +: 4];
      `IPSA_MODE_SPD: digit = sel_i[`IPSA_DIG_SPD_LSB +: 4];
      `IPSA_MODE_TRQ: digit = sel_i[`IPSA_DIG_TRQ_LSB +: 4];
      default: digit = `IPSA_FUNC_NONE;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      func_o <= `IPSA_FUNC_NONE;
      level_o <= 1'b0;
    end else begin
      level_o <= sync2_reg;
      if (abs_force_i)
        func_o <= abs_func_i;
      else if (lop_here_i)
        func_o <= `IPSA_FUNC_NONE;
      else
        func_o <= digit;
    end
  end

endmodule

//--- hdl/ipsa_input_pin_assign.v
// Purpose: route logical input functions to connector input pins
// Assumes: avalon-mm slave, word addresses, one-cycle answer
// Notes: per-function levels are an or of pins carrying that function
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ipsa_map.vh"

// Behaviour
// - The a8 selection register routes any selectable function to connector a pin 8.
// - The b7 selection register routes any selectable function to connector b pin 7.
// - The b8 selection register routes any selectable function to connector b pin 8.
// - The b9 selection register routes any selectable function to connector b pin 9.
// - The a8, b7, b8 and b9 registers use the same code set and layout as the b5 register.
// - The a8 selection is ignored while the control-mode change input sits on that pin.
// - The b7 selection is never ignored; no control-mode change input code names that pin.
// - The b8 selection is ignored only with absolute position enabled; no control-mode change input code names that pin.
// - The b9 selection is ignored while the control-mode change input sits on that pin.
// - With absolute position enabled, pin b8 becomes the transfer mode input.
// - With absolute position enabled, pin b9 becomes the position request input.
// - The a8, b7 and b8 registers reset to 0665, 0770 and 0883.
// - The b9, b5 and b14 registers reset to 0994, 0111 and 0222.
module ipsa_input_pin_assign #(
  parameter SEL_W = 16,
  parameter NPIN = 6,
  parameter NFUNC = 16
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [`IPSA_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output reg [1:0] avs_response_o,
  input wire [NPIN-1:0] pin_i,
  input wire lop_pin_i,
  output reg [NFUNC-1:0] func_level_o,
  output reg [1:0] active_mode_o,
  output reg abs_mode_o,
  output reg abs_request_o
);

  reg [SEL_W-1:0] sel_reg [0:NPIN-1];
  reg [31:0] ctrl_reg;
  reg ack_reg;
  reg lop_s1_reg;
  reg lop_s2_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [31:0] rdata_next;
  reg [NFUNC-1:0] level_next;
  reg hit;
  wire [4*NPIN-1:0] func_w;
  wire [NPIN-1:0] lvl_w;
  wire [NPIN-1:0] lop_here;
  wire [NPIN-1:0] abs_force;
  wire [4*NPIN-1:0] abs_func;
  wire [1:0] base_mode;
  wire [1:0] sw_mode;
  wire abs_en;
  wire [2:0] lop_pin;
  integer k;
  genvar g;

  assign base_mode = ctrl_reg[`IPSA_CTRL_MODE_MSB:`IPSA_CTRL_MODE_LSB];
  assign sw_mode = ctrl_reg[`IPSA_CTRL_MODE_SW_MSB:`IPSA_CTRL_MODE_SW_LSB];
  assign abs_en = ctrl_reg[`IPSA_CTRL_ABS_BIT];
  assign lop_pin = ctrl_reg[`IPSA_CTRL_LOP_MSB:`IPSA_CTRL_LOP_LSB];

  // --------------------------------
  // bus slave, one-cycle answer
  // --------------------------------
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;

  always @* begin
    hit = (avs_address_i <= `IPSA_OFF_PINS);
    rdata_next = 32'h0000_0000;
    case (avs_address_i)
      `IPSA_OFF_SEL_B5: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_B5]};
      `IPSA_OFF_SEL_B14: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_B14]};
      `IPSA_OFF_SEL_A8: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_A8]};
      `IPSA_OFF_SEL_B7: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_B7]};
      `IPSA_OFF_SEL_B8: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_B8]};
      `IPSA_OFF_SEL_B9: rdata_next = {16'h0000, sel_reg[`IPSA_PIN_B9]};
      `IPSA_OFF_CTRL: rdata_next = ctrl_reg;
      `IPSA_OFF_STATUS: rdata_next = {16'h0000, func_level_o};
      `IPSA_OFF_PINS: rdata_next = {22'h0, abs_en, lop_s2_reg, mode_reg, lvl_w};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_reg[`IPSA_PIN_A8] <= `IPSA_RST_SEL_A8;
      sel_reg[`IPSA_PIN_B7] <= `IPSA_RST_SEL_B7;
      sel_reg[`IPSA_PIN_B8] <= `IPSA_RST_SEL_B8;
      sel_reg[`IPSA_PIN_B9] <= `IPSA_RST_SEL_B9;
      sel_reg[`IPSA_PIN_B5] <= `IPSA_RST_SEL_B5;
      sel_reg[`IPSA_PIN_B14] <= `IPSA_RST_SEL_B14;
      ctrl_reg <= `IPSA_RST_CTRL | ({29'h0, `IPSA_RST_LOP_PIN} << `IPSA_CTRL_LOP_LSB);
      ack_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      if ((avs_read_i | avs_write_i) & ~ack_reg) begin
        avs_readdata_o <= avs_read_i ? rdata_next : 32'h0000_0000;
        avs_response_o <= hit ? 2'h0 : 2'h3;
      end
      // write lands at the edge where waitrequest is low
      if (avs_write_i & ack_reg & hit) begin
        // same code set and layout for every selection register
        for (k = 0; k < NPIN; k = k + 1) begin
          if (avs_address_i == k[`IPSA_ADDR_W-1:0]) begin
            if (avs_byteenable_i[0])
              sel_reg[k][7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
              sel_reg[k][15:8] <= avs_writedata_i[15:8];
          end
        end
        if (avs_address_i == `IPSA_OFF_CTRL) begin
          for (k = 0; k < 4; k = k + 1) begin
            if (avs_byteenable_i[k])
              ctrl_reg[8*k +: 8] <= avs_writedata_i[8*k +: 8];
          end
        end
      end
    end
  end

  // --------------------------------
  // active control mode
  // --------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lop_s1_reg <= 1'b0;
      lop_s2_reg <= 1'b0;
    end else begin
      lop_s1_reg <= lop_pin_i;
      lop_s2_reg <= lop_s1_reg;
    end
  end

  // next control mode from the change mode and the synchronised change input
  always @* begin
    case (sw_mode)
      `IPSA_SW_PS: mode_next = lop_s2_reg ? `IPSA_MODE_SPD : `IPSA_MODE_POS;
      `IPSA_SW_ST: mode_next = lop_s2_reg ? `IPSA_MODE_TRQ : `IPSA_MODE_SPD;
      `IPSA_SW_TP: mode_next = lop_s2_reg ? `IPSA_MODE_POS : `IPSA_MODE_TRQ;
      default: mode_next = base_mode;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      mode_reg <= `IPSA_MODE_POS;
    else
      mode_reg <= mode_next;
  end

  // --------------------------------
  // per-pin routing
  // --------------------------------
  assign lop_here[`IPSA_PIN_B5] = (sw_mode != `IPSA_SW_NONE) &&
    (lop_pin == `IPSA_LOP_B5);
  assign lop_here[`IPSA_PIN_B14] = (sw_mode != `IPSA_SW_NONE) &&
    (lop_pin == `IPSA_LOP_B14);
  assign lop_here[`IPSA_PIN_A8] = (sw_mode != `IPSA_SW_NONE) &&
    (lop_pin == `IPSA_LOP_A8);
  assign lop_here[`IPSA_PIN_B7] = 1'b0; // no change-input code names this pin
  assign lop_here[`IPSA_PIN_B8] = 1'b0; // no change-input code names this pin
  assign lop_here[`IPSA_PIN_B9] = (sw_mode != `IPSA_SW_NONE) &&
    (lop_pin == `IPSA_LOP_B9);

  assign abs_force = {abs_en, abs_en, 4'h0};
  assign abs_func = {`IPSA_FUNC_ABS_POSITION_REQUEST, `IPSA_FUNC_ABS_POSITION_TRANSFER_MODE, 16'h0000};

  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gen_pin
      // a8 b7 b8 b9 b5 and b14
      ipsa_pin_route #(
        .SEL_W(SEL_W)
      ) u_route (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pin_i[g]),
        .sel_i(sel_reg[g]),
        .mode_i(mode_reg),
        .lop_here_i(lop_here[g]),
        .abs_force_i(abs_force[g]),
        .abs_func_i(abs_func[4*g +: 4]),
        .func_o(func_w[4*g +: 4]),
        .level_o(lvl_w[g])
      );
    end
  endgenerate

  // --------------------------------
  // function levels
  // --------------------------------
  always @* begin
    level_next = {NFUNC{1'b0}};
    for (k = 0; k < NPIN; k = k + 1) begin
      if (func_w[4*k +: 4] != `IPSA_FUNC_NONE)
        level_next[func_w[4*k +: 4]] = level_next[func_w[4*k +: 4]] | lvl_w[k];
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      func_level_o <= {NFUNC{1'b0}};
      active_mode_o <= `IPSA_MODE_POS;
      abs_mode_o <= 1'b0;
      abs_request_o <= 1'b0;
    end else begin
      func_level_o <= level_next;
      active_mode_o <= mode_reg;
      abs_mode_o <= abs_en & lvl_w[`IPSA_PIN_B8];
      abs_request_o <= abs_en & lvl_w[`IPSA_PIN_B9];
    end
  end

endmodule

//--- verification/ipsa_check_monitor.sv
// Purpose: port checker for the pin assignment block
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "ipsa_map.vh"
module ipsa_check_monitor #(
  parameter NPIN = 6,
  parameter NFUNC = 16
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [`IPSA_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [1:0] avs_response_o,
  input wire [NPIN-1:0] pin_i,
  input wire [NFUNC-1:0] func_level_o,
  input wire [1:0] active_mode_o,
  input wire abs_mode_o,
  input wire abs_request_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire req = avs_read_i || avs_write_i;
  chk_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle at request start");
  chk_unmapped_resp: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h8
    |-> avs_response_o == 2'h3 && avs_readdata_o == 32'h0)
    else $error("unmapped read answered wrongly");
  chk_mapped_resp: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i < 4'h6
    |-> avs_response_o == 2'h0 && avs_readdata_o[31:16] == 16'h0)
    else $error("selection read answered wrongly");
  chk_mode_legal: assert property (active_mode_o != 2'h3)
    else $error("illegal control mode");
  chk_reset_quiet: assert property ($rose(resetn_i) |-> func_level_o == 0 &&
    active_mode_o == 2'h0 && !abs_mode_o && !abs_request_o)
    else $error("outputs not idle after reset");
  chk_abs_mode: assert property ($rose(abs_mode_o) |-> $past(pin_i[4], 3))
    else $error("transfer mode without pin b8");
  chk_abs_request: assert property ($rose(abs_request_o) |-> $past(pin_i[5], 3))
    else $error("position request without pin b9");
endmodule

//--- verification/ipsa_ctrl_model.sv
// Purpose: motion controller model driving the input pins
// Assumes: pins change just after a clock edge
// Notes: levels follow the command one edge later
`timescale 1ns/1ps
module ipsa_ctrl_model (
  input wire clk_i,
  input wire resetn_i,
  input wire [5:0] pin_cmd_i,
  input wire lop_cmd_i,
  output reg [5:0] pin_o,
  output reg lop_o
);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_o <= 6'h00;
      lop_o <= 1'b0;
    end else begin
      pin_o <= pin_cmd_i;
      lop_o <= lop_cmd_i;
    end
  end
endmodule

//--- verification/ipsa_input_pin_assign_test.sv
// Purpose: self-checking bench for the pin assignment block
// Assumes: one wait cycle per bus access
// Notes: pins settle within eight edges
`timescale 1ns/1ps
`include "ipsa_map.vh"
module ipsa_input_pin_assign_test;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [5:0] pin_cmd = 6'h00;
  logic lop_cmd = 1'b0;
  wire [31:0] rdata;
  wire wait_o;
  wire [1:0] resp;
  wire [5:0] pins;
  wire control_mode_change;
  wire [15:0] func;
  wire [1:0] mode;
  wire abs_m;
  wire abs_r;
  integer mismatches = 0;
  integer n_compared = 0;
  logic [31:0] q;
  logic [15:0] rstv [0:5];
  always #25 clk_i = ~clk_i;
  ipsa_ctrl_model model_u (.clk_i(clk_i), .resetn_i(resetn_i), .pin_cmd_i(pin_cmd),
    .lop_cmd_i(lop_cmd), .pin_o(pins), .lop_o(control_mode_change));
  ipsa_input_pin_assign dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .avs_response_o(resp),
    .pin_i(pins), .lop_pin_i(control_mode_change), .func_level_o(func), .active_mode_o(mode),
    .abs_mode_o(abs_m), .abs_request_o(abs_r));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= !we;
    wr <= we;
    wdata <= d;
    do begin
      @(posedge clk_i);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task settle(input logic [5:0] p, input logic l);
    pin_cmd <= p;
    lop_cmd <= l;
    repeat (8) @(posedge clk_i);
  endtask
  function automatic [3:0] code(input integer k, input integer m);
    code = (m == 0) ? 4'(k + 1) : (m == 1) ? 4'(k + 7) : 4'(13 - k);
  endfunction
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test;
  end
  initial begin
    rstv = '{16'h0111, 16'h0222, 16'h0665, 16'h0770, 16'h0883, 16'h0994};
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, 4'(k), 32'h0);
      check("sel reset", q, {16'h0, rstv[k]});
    end
    bus(1'b0, 4'hC, 32'h0);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 4'(k), {20'h0, code(k, 2), code(k, 1), code(k, 0)});
      bus(1'b0, 4'(k), 32'h0);
      check("sel rw", q, {20'h0, code(k, 2), code(k, 1), code(k, 0)});
    end
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, 4'h6, 32'(m));
      for (int k = 0; k < 6; k++) begin
        settle(6'(1 << k), 1'b0);
        check("func", {16'h0, func}, 32'(1) << code(k, m));
      end
      check("mode", {30'h0, mode}, 32'(m));
    end
    bus(1'b1, 4'h6, 32'h0000_0204);
    settle(6'h04, 1'b0);
    check("a8 claimed", {16'h0, func[15:1], 1'b0}, 32'h0);
    settle(6'h08, 1'b0);
    check("b7 kept", {16'h0, func}, 32'(1) << code(3, 0));
    settle(6'h10, 1'b0);
    check("b8 kept", {16'h0, func}, 32'(1) << code(4, 0));
    settle(6'h01, 1'b1);
    check("lop mode", {30'h0, mode}, 32'h1);
    check("b5 spd", {16'h0, func}, 32'h80);
    bus(1'b1, 4'h6, 32'h0000_0404);
    settle(6'h20, 1'b1);
    check("b9 claimed", {16'h0, func[15:1], 1'b0}, 32'h0);
    bus(1'b1, 4'h6, 32'h10);
    settle(6'h10, 1'b0);
    check("abs mode", {15'h0, abs_m, func}, 32'h14000);
    settle(6'h20, 1'b0);
    check("abs req", {15'h0, abs_r, func}, 32'h18000);
    bus(1'b0, 4'h7, 32'h0);
    check("status", q, 32'h8000);
    bus(1'b0, 4'h8, 32'h0);
    check("pins", q, 32'h220);
    end_of_test;
  end
endmodule
bind ipsa_input_pin_assign ipsa_check_monitor #(.NPIN(NPIN), .NFUNC(NFUNC)) mon_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .pin_i(pin_i),
  .func_level_o(func_level_o), .active_mode_o(active_mode_o), .abs_mode_o(abs_mode_o),
  .abs_request_o(abs_request_o));
